// ===== design/rms_device.sv
// device end: reset pin sequencing, cause capture, boot mode and debug receiver
`timescale 1ns/1ps
`include "rms_params.svh"
module rms_device #(
  parameter int PULSE_BUS_CYCLES = `RMS_PULSE_BUS_CYCLES,
  parameter int BIT_CYCLES       = `RMS_BIT_CYCLES
)(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  rms_link_if.device       link,
  input  wire logic        cop_rst_req,
  input  wire logic        illop_rst_req,
  input  wire logic        illaddr_rst_req,
  input  wire logic        lvd_rst_req,
  output logic             system_bus_clock,
  output logic             cpu_reset_n,
  output logic             background_debug_state,
  output logic             run_mode,
  output rms_pkg::rms_cause_t reset_cause_status,
  output logic             clk_from_internal,
  output logic [15:0]      reset_vector_addr,
  output logic             debug_cmd_valid,
  output logic [7:0]       debug_cmd
);
  import rms_pkg::*;

  localparam int DRIVE_CYCLES = PULSE_BUS_CYCLES * `RMS_BUS_DIV;

  // ----------------------------------------------------------------
  // pin synchronisers and bus clock
  // ----------------------------------------------------------------
  logic rst_m_q;
  logic rst_s_q;
  logic ms_m_q;
  logic ms_s_q;
  logic ms_prev_q;
  logic system_bus_clock_q;
  logic system_bus_clock_d;

  assign system_bus_clock_d = rst_n ? !system_bus_clock_q : 1'b0;

  always_ff @(posedge mclk)
  begin
    rst_m_q   <= link.rst_pin_level;
    rst_s_q   <= rst_m_q;
    ms_m_q    <= link.ms_pin_level;
    ms_s_q    <= ms_m_q;
    ms_prev_q <= ms_s_q;
    system_bus_clock_q  <= system_bus_clock_d;
  end

  assign system_bus_clock = system_bus_clock_q;

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  rms_rst_state_t st_q;
  rms_rst_state_t st_d;
  logic [7:0]     cnt_q;
  logic [7:0]     cnt_d;
  rms_cause_t     cause_q;
  rms_cause_t     cause_d;
  logic           sel_q;
  logic           sel_d;
  logic           bdm_q;
  logic           bdm_d;
  logic           drive_q;
  logic           drive_d;
  logic           run_q;
  logic           run_d;
  logic           cmdv_q;
  logic [7:0]     cmd_q;
  rms_cause_t     src;
  logic           force_rst;

  assign force_rst = cmdv_q && (cmd_q == `RMS_CMD_FORCE_RESET);

  always_comb
  begin
    src                  = '0;
    src[`RMS_CAUSE_PIN]  = !rst_s_q;
    src[`RMS_CAUSE_COP]  = cop_rst_req;
    src[`RMS_CAUSE_ILOP] = illop_rst_req;
    src[`RMS_CAUSE_ILAD] = illaddr_rst_req;
    src[`RMS_CAUSE_DBGF] = force_rst;
    src[`RMS_CAUSE_LVD]  = lvd_rst_req;
  end

  always_comb
  begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    cause_d = cause_q;
    sel_d   = sel_q;
    bdm_d   = bdm_q;
    unique case (st_q)
      RMS_ST_POWERUP:
      begin
        st_d    = RMS_ST_DRIVE;
        cnt_d   = '0;
        cause_d = rms_cause_t'(1) << `RMS_CAUSE_POR;
        sel_d   = 1'b1;
      end
      RMS_ST_DRIVE:
      begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == 8'(DRIVE_CYCLES - 1))
        begin
          st_d = RMS_ST_WAIT;
        end
      end
      RMS_ST_WAIT:
      begin
        // an outside party may still hold the pin low; stay in reset
        if (rst_s_q)
        begin
          st_d  = RMS_ST_RUN;
          bdm_d = sel_q && !ms_s_q;
        end
      end
      RMS_ST_RUN:
      begin
        if (src != '0)
        begin
          st_d    = RMS_ST_DRIVE;
          cnt_d   = '0;
          cause_d = src;
          sel_d   = force_rst;
          bdm_d   = 1'b0;
        end
        else if (cmdv_q && (cmd_q == `RMS_CMD_BACKGROUND))
        begin
          bdm_d = 1'b1;
        end
      end
    endcase
    drive_d = (st_d == RMS_ST_POWERUP) || (st_d == RMS_ST_DRIVE);
    run_d   = (st_d == RMS_ST_RUN);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_q    <= RMS_ST_POWERUP;
      cnt_q   <= '0;
      cause_q <= '0;
      sel_q   <= 1'b1;
      bdm_q   <= 1'b0;
      drive_q <= 1'b1;
      run_q   <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      cause_q <= cause_d;
      sel_q   <= sel_d;
      bdm_q   <= bdm_d;
      drive_q <= drive_d;
      run_q   <= run_d;
    end
  end

  assign link.dev_rst_oe     = drive_q;
  assign link.dev_rst_out    = 1'b0;
  assign cpu_reset_n         = run_q;
  assign background_debug_state = bdm_q;
  assign run_mode            = run_q && !bdm_q;
  assign reset_cause_status  = cause_q;
  assign clk_from_internal   = 1'b1;
  assign reset_vector_addr   = `RMS_RESET_VECTOR;

  // ----------------------------------------------------------------
  // serial debug receiver, live only outside reset
  // ----------------------------------------------------------------
  rms_rx_state_t rx_q;
  rms_rx_state_t rx_d;
  logic [3:0]    bcnt_q;
  logic [3:0]    bcnt_d;
  logic [2:0]    nb_q;
  logic [2:0]    nb_d;
  logic [7:0]    sh_q;
  logic [7:0]    sh_d;
  logic          cmdv_d;
  logic [7:0]    cmd_d;
  logic          mse_q;
  logic          mse_d;
  logic          mso_q;
  logic          mso_d;

  always_comb
  begin
    rx_d   = rx_q;
    bcnt_d = bcnt_q;
    nb_d   = nb_q;
    sh_d   = sh_q;
    cmdv_d = 1'b0;
    cmd_d  = cmd_q;
    mse_d  = 1'b0;
    mso_d  = 1'b0;
    if (st_q != RMS_ST_RUN)
    begin
      rx_d   = RMS_RX_IDLE;
      bcnt_d = '0;
      nb_d   = '0;
    end
    else
    begin
      unique case (rx_q)
        RMS_RX_IDLE:
        begin
          if (ms_prev_q && !ms_s_q)
          begin
            rx_d   = RMS_RX_BIT;
            bcnt_d = '0;
          end
        end
        RMS_RX_BIT:
        begin
          bcnt_d = bcnt_q + 4'h1;
          if (bcnt_q == 4'(`RMS_RX_SAMPLE))
          begin
            sh_d = {sh_q[6:0], ms_s_q};
          end
          // window closes before the next bit start, sync lag included
          if (bcnt_q == 4'(`RMS_RX_WINDOW))
          begin
            bcnt_d = '0;
            rx_d   = RMS_RX_IDLE;
            nb_d   = nb_q + 3'h1;
            if (nb_q == 3'h7)
            begin
              cmdv_d = 1'b1;
              cmd_d  = sh_q;
              // a forced reset answers by itself, no ack
              rx_d   = (sh_q == `RMS_CMD_FORCE_RESET) ? RMS_RX_IDLE : RMS_RX_ACK;
            end
          end
        end
        RMS_RX_ACK:
        begin
          mse_d  = 1'b1;
          bcnt_d = bcnt_q + 4'h1;
          if (bcnt_q == 4'(`RMS_ACK_LOW_CYCLES - 1))
          begin
            rx_d = RMS_RX_SPEED;
          end
        end
        RMS_RX_SPEED:
        begin
          mse_d  = 1'b1;
          mso_d  = 1'b1;
          bcnt_d = '0;
          rx_d   = RMS_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rx_q   <= RMS_RX_IDLE;
      bcnt_q <= '0;
      nb_q   <= '0;
      sh_q   <= '0;
      cmdv_q <= 1'b0;
      cmd_q  <= '0;
      mse_q  <= 1'b0;
      mso_q  <= 1'b0;
    end
    else
    begin
      rx_q   <= rx_d;
      bcnt_q <= bcnt_d;
      nb_q   <= nb_d;
      sh_q   <= sh_d;
      cmdv_q <= cmdv_d;
      cmd_q  <= cmd_d;
      mse_q  <= mse_d;
      mso_q  <= mso_d;
    end
  end

  assign link.dev_ms_oe  = mse_q;
  assign link.dev_ms_out = mso_q;
  assign debug_cmd_valid = cmdv_q;
  assign debug_cmd       = cmd_q;
endmodule

// ===== design/rms_params.svh
// timing counts, command codes and field positions for reset and mode select
`ifndef RMS_PARAMS_SVH
`define RMS_PARAMS_SVH

`define RMS_PULSE_BUS_CYCLES 66
`define RMS_BUS_DIV          2
`define RMS_BIT_CYCLES       16
`define RMS_ONE_LOW_CYCLES   4
`define RMS_ZERO_LOW_CYCLES  13
`define RMS_RX_SAMPLE        8
`define RMS_RX_WINDOW        11
`define RMS_ACK_LOW_CYCLES   16
`define RMS_CMD_BACKGROUND   8'h90
`define RMS_CMD_FORCE_RESET  8'hC4
`define RMS_RESET_VECTOR     16'hFFFE
`define RMS_CAUSE_POR        7
`define RMS_CAUSE_PIN        6
`define RMS_CAUSE_COP        5
`define RMS_CAUSE_ILOP       4
`define RMS_CAUSE_ILAD       3
`define RMS_CAUSE_DBGF       2
`define RMS_CAUSE_LVD        1

`endif

// ===== design/rms_pkg.sv
// types shared by both ends of the reset and mode select link
package rms_pkg;

  typedef logic [7:0] rms_cause_t;

  typedef enum logic [1:0]
  {
    RMS_ST_POWERUP = 2'b00,
    RMS_ST_DRIVE   = 2'b01,
    RMS_ST_WAIT    = 2'b10,
    RMS_ST_RUN     = 2'b11
  } rms_rst_state_t;

  typedef enum logic [1:0]
  {
    RMS_RX_IDLE  = 2'b00,
    RMS_RX_BIT   = 2'b01,
    RMS_RX_ACK   = 2'b10,
    RMS_RX_SPEED = 2'b11
  } rms_rx_state_t;

  typedef enum logic [1:0]
  {
    RMS_TX_IDLE = 2'b00,
    RMS_TX_BIT  = 2'b01,
    RMS_TX_WAIT = 2'b10
  } rms_tx_state_t;

endpackage

// ===== design/rms_link_if.sv
// pin-level link: open-drain reset pin and pseudo open-drain mode/debug pin
`timescale 1ns/1ps
interface rms_link_if;
  logic dev_rst_oe;
  logic dev_rst_out;
  logic host_rst_oe;
  logic host_rst_out;
  logic dev_ms_oe;
  logic dev_ms_out;
  logic host_ms_oe;
  logic host_ms_out;
  logic rst_pin_level;
  logic ms_pin_level;

  // pull-ups make both pins high when nobody pulls low
  assign rst_pin_level = !((dev_rst_oe && !dev_rst_out) || (host_rst_oe && !host_rst_out));
  assign ms_pin_level  = !((dev_ms_oe && !dev_ms_out) || (host_ms_oe && !host_ms_out));

  modport device
  (
    output dev_rst_oe,
    output dev_rst_out,
    output dev_ms_oe,
    output dev_ms_out,
    input  rst_pin_level,
    input  ms_pin_level
  );

  modport host
  (
    output host_rst_oe,
    output host_rst_out,
    output host_ms_oe,
    output host_ms_out,
    input  rst_pin_level,
    input  ms_pin_level
  );
endinterface

// ===== design/rms_host.sv
// host end: external reset switch, mode-select hold and debug command sender
`timescale 1ns/1ps
`include "rms_params.svh"
module rms_host #(
  parameter int BIT_CYCLES = `RMS_BIT_CYCLES
)(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  rms_link_if.host        link,
  input  wire logic       hold_reset,
  input  wire logic       hold_ms_low,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  output logic            cmd_ready,
  output logic            ack_seen,
  output logic            target_in_reset
);
  import rms_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic rst_m_q;
  logic rst_s_q;
  logic ms_m_q;
  logic ms_s_q;

  always_ff @(posedge mclk)
  begin
    rst_m_q <= link.rst_pin_level;
    rst_s_q <= rst_m_q;
    ms_m_q  <= link.ms_pin_level;
    ms_s_q  <= ms_m_q;
  end

  // ----------------------------------------------------------------
  // command sender
  // ----------------------------------------------------------------
  rms_tx_state_t tx_q;
  rms_tx_state_t tx_d;
  logic [3:0]    cyc_q;
  logic [3:0]    cyc_d;
  logic [2:0]    nb_q;
  logic [2:0]    nb_d;
  logic [7:0]    sh_q;
  logic [7:0]    sh_d;
  logic          low_q;
  logic          low_d;
  logic          ack_q;
  logic          ack_d;
  logic          tre_q;
  logic          mse_q;
  logic          mse_d;
  logic          mso_q;
  logic          mso_d;
  logic [3:0]    low_len;

  assign low_len = sh_q[7] ? 4'(`RMS_ONE_LOW_CYCLES) : 4'(`RMS_ZERO_LOW_CYCLES);

  always_comb
  begin
    tx_d  = tx_q;
    cyc_d = cyc_q;
    nb_d  = nb_q;
    sh_d  = sh_q;
    low_d = low_q;
    ack_d = 1'b0;
    mse_d = 1'b0;
    mso_d = 1'b0;
    unique case (tx_q)
      RMS_TX_IDLE:
      begin
        if (cmd_valid)
        begin
          tx_d  = RMS_TX_BIT;
          sh_d  = cmd_byte;
          cyc_d = '0;
          nb_d  = '0;
        end
      end
      RMS_TX_BIT:
      begin
        cyc_d = cyc_q + 4'h1;
        mse_d = (cyc_q <= low_len);
        mso_d = (cyc_q == low_len);
        if (cyc_q == 4'(BIT_CYCLES - 1))
        begin
          cyc_d = '0;
          sh_d  = {sh_q[6:0], 1'b0};
          nb_d  = nb_q + 3'h1;
          if (nb_q == 3'h7)
          begin
            tx_d  = RMS_TX_WAIT;
            low_d = 1'b0;
          end
        end
      end
      RMS_TX_WAIT:
      begin
        // ack is a low stretch then high; a forced reset ends the wait too
        if (!ms_s_q)
        begin
          low_d = 1'b1;
        end
        if (low_q && ms_s_q)
        begin
          ack_d = 1'b1;
          tx_d  = RMS_TX_IDLE;
        end
        else if (!rst_s_q)
        begin
          tx_d = RMS_TX_IDLE;
        end
      end
      default:
      begin
        tx_d = RMS_TX_IDLE;
      end
    endcase
    if (hold_ms_low)
    begin
      mse_d = 1'b1;
      mso_d = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tx_q  <= RMS_TX_IDLE;
      cyc_q <= '0;
      nb_q  <= '0;
      sh_q  <= '0;
      low_q <= 1'b0;
      ack_q <= 1'b0;
      tre_q <= 1'b0;
      mse_q <= 1'b0;
      mso_q <= 1'b0;
    end
    else
    begin
      tx_q  <= tx_d;
      cyc_q <= cyc_d;
      nb_q  <= nb_d;
      sh_q  <= sh_d;
      low_q <= low_d;
      ack_q <= ack_d;
      tre_q <= !rst_s_q;
      mse_q <= mse_d;
      mso_q <= mso_d;
    end
  end

  assign cmd_ready        = (tx_q == RMS_TX_IDLE);
  assign ack_seen         = ack_q;
  assign target_in_reset  = tre_q;
  assign link.host_ms_oe  = mse_q;
  assign link.host_ms_out = mso_q;
  assign link.host_rst_oe  = hold_reset;
  assign link.host_rst_out = 1'b0;
endmodule

// ===== tb/rms_assertions.sv
// concurrent checks on the link pins and device outputs of reset and mode select
`timescale 1ns/1ps
module rms_assertions
(
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire logic                dev_rst_oe,
  input wire logic                dev_rst_out,
  input wire logic                dev_ms_oe,
  input wire logic                dev_ms_out,
  input wire logic                rst_pin_level,
  input wire logic                ms_pin_level,
  input wire logic                system_bus_clock,
  input wire logic                cpu_reset_n,
  input wire logic                background_debug_state,
  input wire logic                clk_from_internal,
  input wire rms_pkg::rms_cause_t reset_cause_status
);
  import rms_pkg::*;
  logic [7:0] len_q;
  logic       armed_q;
  logic       dev_low;

  // ----------------------------------------
  // pulse length helper
  // ----------------------------------------
  // the power-on pulse starts inside reset, so only pulses seen to start are timed
  assign dev_low = dev_ms_oe && !dev_ms_out;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      len_q   <= 8'h00;
      armed_q <= 1'b0;
    end
    else
    begin
      len_q   <= dev_rst_oe ? len_q + 8'h01 : 8'h00;
      armed_q <= armed_q || !dev_rst_oe;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_RST_OPEN_DRAIN: assert property (dev_rst_oe |-> !dev_rst_out && !rst_pin_level)
    else $error("reset pin not pulled low while driven");
  AST_RST_PULSE_LEN: assert property (armed_q && $fell(dev_rst_oe) |-> len_q == 8'h84)
    else $error("reset pin pulse length wrong");
  AST_CPU_HELD: assert property (dev_rst_oe |-> !cpu_reset_n)
    else $error("cpu released while reset pin driven");
  AST_BUS_HALF: assert property ($past(rst_n) |-> system_bus_clock != $past(system_bus_clock))
    else $error("bus clock not half rate");
  AST_INT_CLK: assert property (clk_from_internal)
    else $error("internal clock not selected");
  AST_PIN_USER: assert property ($rose(cpu_reset_n) && reset_cause_status == 8'h40 |-> !background_debug_state)
    else $error("pin reset entered background");
  AST_BOOT_RUN: assert property ($rose(cpu_reset_n) && (reset_cause_status[7] || reset_cause_status[2])
    && $past(ms_pin_level, 2) && $past(ms_pin_level, 3) |-> !background_debug_state)
    else $error("mode pin high but background entered");
  AST_BOOT_BDM: assert property ($rose(cpu_reset_n) && (reset_cause_status[7] || reset_cause_status[2])
    && !$past(ms_pin_level, 2) && !$past(ms_pin_level, 3) |-> background_debug_state)
    else $error("mode pin low but background not entered");
  AST_MS_QUIET: assert property (!cpu_reset_n |-> !dev_ms_oe)
    else $error("mode pin driven during reset");
  AST_ACK_LEN: assert property ($rose(dev_low) |-> dev_low[*8] ##1 dev_low[*8] ##1
    (dev_ms_oe && dev_ms_out) ##1 !dev_ms_oe)
    else $error("ack low time or speedup wrong");
endmodule

// ===== tb/testbench.sv
// self-checking bench joining the device and host ends of the link
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module testbench;
  import rms_pkg::*;
  logic        mclk, rst_n, hold_reset, hold_ms_low, cmd_valid, cmd_ready, ack_seen, target_in_reset;
  logic        cop_rst_req, illop_rst_req, illaddr_rst_req, lvd_rst_req;
  logic        system_bus_clock, cpu_reset_n, background_debug_state, run_mode, clk_from_internal;
  logic        debug_cmd_valid;
  logic [7:0]  cmd_byte, debug_cmd, last_cmd;
  logic [15:0] reset_vector_addr;
  rms_cause_t  reset_cause_status;
  int          num_errors = 0, cmp_count = 0, cyc = 0, low_len = 0, spd = 0, acks = 0;
  int          runs[$];
  int          falls[$];

  rms_link_if link_bus();
  rms_device u_rms_device (.mclk, .rst_n, .link(link_bus.device), .cop_rst_req, .illop_rst_req,
    .illaddr_rst_req, .lvd_rst_req, .system_bus_clock, .cpu_reset_n, .background_debug_state, .run_mode,
    .reset_cause_status, .clk_from_internal, .reset_vector_addr, .debug_cmd_valid, .debug_cmd);
  rms_host u_rms_host (.mclk, .rst_n, .link(link_bus.host), .hold_reset, .hold_ms_low, .cmd_valid,
    .cmd_byte, .cmd_ready, .ack_seen, .target_in_reset);
  rms_assertions u_rms_assertions (.mclk, .rst_n, .dev_rst_oe(link_bus.dev_rst_oe),
    .dev_rst_out(link_bus.dev_rst_out), .dev_ms_oe(link_bus.dev_ms_oe), .dev_ms_out(link_bus.dev_ms_out),
    .rst_pin_level(link_bus.rst_pin_level), .ms_pin_level(link_bus.ms_pin_level), .system_bus_clock,
    .cpu_reset_n, .background_debug_state, .clk_from_internal, .reset_cause_status);

  // ----------------------------------------
  // clock, wire monitor and timeout
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // sampled mid-cycle so registered pin drivers have settled
  always @(negedge mclk)
  begin
    cyc++;
    if (link_bus.ms_pin_level === 1'b0)
    begin
      if (low_len == 0) falls.push_back(cyc);
      low_len++;
    end
    else if (low_len > 0)
    begin
      runs.push_back(low_len);
      low_len = 0;
    end
    if (link_bus.host_ms_oe === 1'b1 && link_bus.host_ms_out === 1'b1) spd++;
    if (debug_cmd_valid === 1'b1) last_cmd = debug_cmd;
    if (ack_seen === 1'b1) acks++;
    if (cyc == 10000)
    begin
      num_errors++;
      finish_test();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wait_cpu(logic lvl);
    for (int i = 0; i < 2000 && cpu_reset_n !== lvl; i++) tick(1);
    `CHK("cpu_reset_n", lvl, cpu_reset_n)
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 2000 && cmd_ready !== 1'b1; i++) tick(1);
    `CHK("cmd_ready", 1'b1, cmd_ready)
  endtask

  task automatic send(logic [7:0] b);
    wait_ready();
    cmd_valid = 1'b1;
    cmd_byte  = b;
    tick(1);
    cmd_valid = 1'b0;
  endtask

  task automatic t_por();
    wait_cpu(1'b1);
    `CHK("cause", 8'h80, reset_cause_status)
    `CHK("run_mode", 1'b1, run_mode)
    `CHK("vector", 16'hFFFE, reset_vector_addr)
  endtask

  // 0xA5 gives both bit kinds, MSB first, then a 16-cycle ack
  task automatic t_other();
    int exp_runs[9] = '{4, 13, 4, 13, 13, 4, 13, 4, 16};
    runs.delete();
    falls.delete();
    spd  = 0;
    acks = 0;
    send(8'hA5);
    wait_ready();
    tick(1);
    `CHK("cmd", 8'hA5, last_cmd)
    `CHK("acks", 1, acks)
    foreach (exp_runs[i]) `CHK("low_run", exp_runs[i], runs[i])
    for (int i = 0; i < 7; i++) `CHK("bit_time", 16, falls[i + 1] - falls[i])
    `CHK("speedups", 8, spd)
  endtask

  task automatic t_background();
    send(8'h90);
    wait_ready();
    `CHK("bdm", 1'b1, background_debug_state)
    `CHK("run_mode", 1'b0, run_mode)
  endtask

  // mode pin held low on purpose: a pin reset must still boot user mode
  task automatic t_pin_reset();
    hold_reset = 1'b1;
    tick(5);
    hold_ms_low = 1'b1;
    tick(150);
    `CHK("in_reset", 1'b1, target_in_reset)
    `CHK("rst_pin", 1'b0, link_bus.rst_pin_level)
    hold_reset = 1'b0;
    wait_cpu(1'b1);
    `CHK("cause", 8'h40, reset_cause_status)
    `CHK("bdm", 1'b0, background_debug_state)
    hold_ms_low = 1'b0;
    tick(4);
  endtask

  task automatic t_internal();
    logic [7:0] exp_cause[4] = '{8'h20, 8'h10, 8'h08, 8'h02};
    for (int k = 0; k < 4; k++)
    begin
      {cop_rst_req, illop_rst_req, illaddr_rst_req, lvd_rst_req} = 4'h8 >> k;
      tick(1);
      {cop_rst_req, illop_rst_req, illaddr_rst_req, lvd_rst_req} = 4'h0;
      wait_cpu(1'b0);
      wait_cpu(1'b1);
      `CHK("cause", exp_cause[k], reset_cause_status)
    end
  endtask

  task automatic t_force(logic ms_low);
    send(8'hC4);
    wait_cpu(1'b0);
    hold_ms_low = ms_low;
    wait_cpu(1'b1);
    `CHK("cause", 8'h04, reset_cause_status)
    `CHK("bdm", ms_low, background_debug_state)
    hold_ms_low = 1'b0;
    wait_ready();
  endtask

  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    rst_n       = 1'b0;
    hold_reset  = 1'b0;
    hold_ms_low = 1'b0;
    cmd_valid   = 1'b0;
    cmd_byte    = 8'h00;
    {cop_rst_req, illop_rst_req, illaddr_rst_req, lvd_rst_req} = 4'h0;
    tick(5);
    rst_n = 1'b1;
    t_por();
    t_other();
    t_background();
    t_pin_reset();
    t_internal();
    t_force(1'b1);
    t_force(1'b0);
    finish_test();
  end
endmodule
